// File: tb/tape_dev_model.sv
// Tape board model: ports, status, wait line, sense bytes
`timescale 1ns/100ps
module tape_dev_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire tape_pkg::dev_out_t dev_o,
  output tape_pkg::dev_in_t dev_i,
  input wire logic [15:0] blocks,
  input wire logic [15:0] abort_at,
  output logic [15:0] total,
  output logic [7:0] proto_err,
  output logic [7:0] wr_bad
);
  tape_pkg::dev_out_t p;
  logic [8:0] log_q [0:15];
  logic [3:0] log_n;
  logic [7:0] last_cmd, lastd, ibf_t, obf_t, busy_t, scnt, sidx, val;
  logic output_buffer_full, intr, xfer, rdy, stall, rd_on, dat, rd_end, wr_end;
  logic [15:0] nt, fin;
  assign nt = total + 16'd1;
  assign fin = {blocks[6:0], 9'h000};
  assign rdy = xfer && busy_t == 8'h00;
  assign dat = !dev_o.cs1_n && !(dev_o.rd_n && dev_o.wr_n);
  assign stall = xfer && dat && scnt < 8'd14;
  // Data only appears once the stretch is over
  assign rd_on = !dev_o.rd_n && !(dev_o.cs0_n && dev_o.cs1_n) && !stall;
  assign rd_end = !p.rd_n && dev_o.rd_n;
  assign wr_end = !p.wr_n && dev_o.wr_n;
  // ==========================================
  // Port read mux, released lines invert
  always_comb begin
    if (!dev_o.cs1_n) val = total[7:0] ^ 8'h3c;
    else if (dev_o.addr0) val = {rdy, 5'h00, ibf_t != 8'h00, output_buffer_full};
    else val = 8'hc0 + sidx;
    dev_i.data = dev_o.data_oe ? dev_o.data : (rd_on ? val : ~lastd);
    dev_i.wait_n = !stall;
    dev_i.intr = intr;
  end
  // ==========================================
  // Access decoding
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      p <= '1;
      {log_n, last_cmd, lastd, ibf_t, obf_t, busy_t, scnt, sidx} <= '0;
      {output_buffer_full, intr, xfer, total, proto_err, wr_bad} <= '0;
    end else begin
      p <= dev_o;
      lastd <= dev_i.data;
      scnt <= dat ? scnt + 8'd1 : 8'h00;
      ibf_t <= ibf_t - 8'(ibf_t != 8'h00);
      busy_t <= busy_t - 8'(busy_t != 8'h00);
      obf_t <= obf_t - 8'(obf_t != 8'h00);
      if (obf_t == 8'h01) output_buffer_full <= 1'b1;
      if (!dev_o.wr_n && !dev_o.data_oe) proto_err <= proto_err + 8'd1;
      if (wr_end && !p.cs0_n) begin
        if (ibf_t != 8'h00) proto_err <= proto_err + 8'd1;
        log_q[log_n] <= {p.addr0, p.data};
        log_n <= log_n + 4'd1;
        ibf_t <= 8'd20;
        if (p.addr0) last_cmd <= p.data;
        else if (last_cmd == tape_pkg::SOT_CODE) begin
          {xfer, busy_t, total, sidx} <= {1'b1, 8'd30, 16'h0000, 8'h00};
        end else if (last_cmd == tape_pkg::EOT_CODE) begin
          {xfer, output_buffer_full} <= 2'b01;
        end
      end
      if (rd_end && !p.cs0_n && !p.addr0 && output_buffer_full) begin
        {output_buffer_full, intr, sidx} <= {2'b00, sidx + 8'd1};
        if (sidx == 8'h00) obf_t <= 8'd15;
      end
      if ((rd_end || wr_end) && !p.cs1_n && xfer) begin
        if (busy_t != 8'h00 || scnt < 8'd14) proto_err <= proto_err + 8'd1;
        if (wr_end && p.data !== (total[7:0] ^ 8'ha5)) wr_bad <= wr_bad + 8'd1;
        total <= nt;
        if (wr_end ? nt[8:0] == 9'h000 && nt != fin : nt[8:0] == 9'h1ff && nt != fin - 16'd1) busy_t <= 8'd30;
        // Interrupt first, output-full later, so both host abort paths are reached
        if (nt == abort_at) {xfer, intr, obf_t} <= {2'b01, 8'd40};
      end
    end
  end
endmodule

// File: tb/tb.sv
// Self-checking bench for the tape programmed-I/O host controller
`timescale 1ns/100ps
module tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic src_valid = 1'b0;
  logic src_en = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [7:0] src_data = 8'ha5;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [15:0] blocks = 16'h0000;
  logic [15:0] abort_at = 16'hffff;
  logic [31:0] prdata, rd;
  logic pready, pslverr, src_ready, snk_valid, err_q;
  logic [7:0] snk_data, proto_err, wr_bad;
  logic [15:0] total, src_idx, snk_cnt, chk_lim;
  logic [2:0] cyc = 3'h0;
  int errors = 0;
  int compares = 0;
  tape_pkg::dev_out_t dev_o;
  tape_pkg::dev_in_t dev_i;
  always #5 mclk = ~mclk;
  tape_pio_host uut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dev_o(dev_o),
    .dev_i(dev_i), .src_data(src_data), .src_valid(src_valid), .src_ready(src_ready),
    .snk_data(snk_data), .snk_valid(snk_valid));
  tape_dev_model mdl (.mclk(mclk), .rst_n(rst_n), .dev_o(dev_o), .dev_i(dev_i), .blocks(blocks),
    .abort_at(abort_at), .total(total), .proto_err(proto_err), .wr_bad(wr_bad));
  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic complete_run();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================
  // Streams; the source stalls every eighth cycle
  always @(posedge mclk) begin
    cyc <= cyc + 3'd1;
    src_valid <= src_en && cyc != 3'd3;
    if (src_valid && src_ready) begin
      src_idx <= src_idx + 16'd1;
      src_data <= (src_idx[7:0] + 8'd1) ^ 8'ha5;
    end
    if (snk_valid === 1'b1) begin
      if (snk_cnt < chk_lim) check(snk_data === (snk_cnt[7:0] ^ 8'h3c), "read byte");
      snk_cnt <= snk_cnt + 16'd1;
    end
  end
  // ==========================================
  // APB master, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Answer and read data are taken at the rising edge that sees pready
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // ==========================================
  // One full operation and its checks
  task automatic run_op(input logic dir, input logic [15:0] n, input logic [15:0] ab, input logic [7:0] op);
    logic [8:0] ex [0:5];
    logic [3:0] s;
    logic abt;
    logic [15:0] fin;
    fin = {n[6:0], 9'h000};
    abt = ab < fin;
    ex = '{{1'b1, op}, 9'h011, {1'b1, tape_pkg::SOT_CODE}, 9'h000, {1'b1, tape_pkg::EOT_CODE}, 9'h000};
    s = mdl.log_n;
    blocks <= n;
    abort_at <= ab;
    chk_lim <= abt ? ab : fin;
    snk_cnt <= 16'h0000;
    src_idx <= 16'h0000;
    src_data <= 8'ha5;
    apb(1'b1, tape_pkg::OFS_COUNT, {8'h00, 8'h02, n});
    apb(1'b1, tape_pkg::OFS_CTRL, {8'h00, 8'h11, op, 6'h00, dir, 1'b1});
    src_en <= dir;
    rd = 32'h0000_0000;
    while (rd[tape_pkg::STAT_DONE] !== 1'b1) apb(1'b0, tape_pkg::OFS_STAT, 32'h0000_0000);
    src_en <= 1'b0;
    check(rd[tape_pkg::STAT_ABORT] === abt, "abort flag");
    check(rd[15:8] === 8'hc0 && rd[23:16] === 8'h02 && mdl.sidx === 8'h02, "sense");
    check(total === (abt ? ab : fin), "byte count");
    check(proto_err === 8'h00 && wr_bad === 8'h00, "port protocol");
    check((dir ? src_idx : snk_cnt) === (abt ? 16'd511 : fin), "stream count");
    for (int k = 0; k < (abt ? 4 : 6); k++) check(mdl.log_q[4'(s + k)] === ex[k], "cmd byte");
    check(mdl.log_n === 4'(s + (abt ? 4 : 6)), "cmd count");
  endtask
  task automatic t_regs();
    apb(1'b0, tape_pkg::OFS_STAT, 32'h0000_0000);
    check(rd === 32'h0000_0000 && err_q === 1'b0, "status at reset");
    check(dev_o.cs0_n & dev_o.cs1_n & dev_o.rd_n & dev_o.wr_n & ~dev_o.data_oe, "idle pins");
    apb(1'b1, tape_pkg::OFS_STAT, 32'hffff_ffff);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    check(err_q === 1'b1 && rd === 32'h0000_0000, "unmapped");
    apb(1'b0, tape_pkg::OFS_STAT, 32'h0000_0000);
    check(rd === 32'h0000_0000, "status write");
    $display("test regs done");
  endtask
  task automatic t_zero_count();
    logic [3:0] s;
    s = mdl.log_n;
    apb(1'b1, tape_pkg::OFS_COUNT, 32'h0002_0000);
    apb(1'b1, tape_pkg::OFS_CTRL, 32'h0011_0401);
    apb(1'b0, tape_pkg::OFS_STAT, 32'h0000_0000);
    check(rd[tape_pkg::STAT_BUSY] === 1'b0 && mdl.log_n === s, "zero count");
    $display("test zero count done");
  endtask
  task automatic t_read_two();
    run_op(1'b0, 16'd2, 16'hffff, 8'h04);
    $display("test read done");
  endtask
  task automatic t_write_two();
    run_op(1'b1, 16'd2, 16'hffff, 8'h02);
    $display("test write done");
  endtask
  task automatic t_read_abort();
    run_op(1'b0, 16'd2, 16'd300, 8'h04);
    $display("test abort done");
  endtask
  // Abort on the 511th byte: the ready poll sees the interrupt before output-full
  task automatic t_read_intr();
    run_op(1'b0, 16'd2, 16'd511, 8'h04);
    $display("test intr done");
  endtask
  initial begin
    {src_idx, snk_cnt, chk_lim} = '0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_read_two();
    t_write_two();
    t_read_abort();
    t_read_intr();
    t_zero_count();
    complete_run();
  end
  initial begin
    repeat (90000) @(posedge mclk);
    errors++;
    $display("unexpected at %0t: timeout", $time);
    complete_run();
  end
endmodule

// File: verilog/tape_pio_host.sv
// Host-side controller driving the tape board's programmed-I/O ports
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module tape_pio_host (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output tape_pkg::dev_out_t dev_o,
  input wire tape_pkg::dev_in_t dev_i,
  input wire logic [7:0] src_data,
  input wire logic src_valid,
  output logic src_ready,
  output logic [7:0] snk_data,
  output logic snk_valid
);

  // ==========================================
  // State and helpers
  tape_pkg::state_t s_reg;
  tape_pkg::state_t s_next;
  logic acc;
  logic apb_wr;
  logic idle;
  logic fin;
  logic start;
  logic strobe;
  logic [7:0] cbyte;

  function automatic tape_pkg::state_t launch(
    input tape_pkg::state_t s,
    input tape_pkg::port_t p,
    input logic w,
    input logic [7:0] d
  );
    launch = s;
    launch.io = tape_pkg::IO_SET;
    launch.port = p;
    launch.wr = w;
    launch.wdata = d;
  endfunction

  // Controller status read sits on the odd base 0 port
  function automatic tape_pkg::state_t poll(input tape_pkg::state_t s);
    poll = launch(s, tape_pkg::PORT_CMD, 1'b0, 8'h00);
  endfunction

  assign acc = psel && penable;
  assign apb_wr = acc && pwrite;
  assign idle = s_reg.ph == tape_pkg::P_IDLE;
  assign fin = s_reg.io == tape_pkg::IO_END;
  assign start = apb_wr && paddr == tape_pkg::OFS_CTRL && pwdata[tape_pkg::CTRL_GO]
    && s_reg.blk != 16'h0000 && idle;
  assign strobe = !dev_o.rd_n || !dev_o.wr_n;

  assign cbyte = s_reg.param ? (s_reg.cmd == tape_pkg::C_OP ? s_reg.opar : tape_pkg::XFER_PARAM) :
    s_reg.cmd == tape_pkg::C_OP ? s_reg.op :
    s_reg.cmd == tape_pkg::C_SOT ? tape_pkg::SOT_CODE : tape_pkg::EOT_CODE;

  // ==========================================
  // APB slave, zero wait
  assign pready = 1'b1;
  assign pslverr = acc && paddr != tape_pkg::OFS_CTRL && paddr != tape_pkg::OFS_COUNT
    && paddr != tape_pkg::OFS_STAT;

  always_comb begin
    prdata = 32'h0000_0000;
    if (paddr == tape_pkg::OFS_CTRL) begin
      prdata[tape_pkg::CTRL_DIR] = s_reg.dir;
      prdata[tape_pkg::CTRL_OP +: 8] = s_reg.op;
      prdata[tape_pkg::CTRL_PAR +: 8] = s_reg.opar;
    end else if (paddr == tape_pkg::OFS_COUNT) begin
      prdata[tape_pkg::COUNT_BLK +: 16] = s_reg.blk;
      prdata[tape_pkg::COUNT_SENSE +: 8] = s_reg.sense_n;
    end else if (paddr == tape_pkg::OFS_STAT) begin
      prdata[tape_pkg::STAT_BUSY] = !idle;
      prdata[tape_pkg::STAT_DONE] = s_reg.done;
      prdata[tape_pkg::STAT_ABORT] = s_reg.abort;
      prdata[tape_pkg::STAT_SENSE0 +: 8] = s_reg.sense0;
      prdata[tape_pkg::STAT_SENSE_N +: 8] = s_reg.sense_i;
      // Last byte read from the device, reserved bits included as seen
      prdata[tape_pkg::STAT_PORT +: 8] = s_reg.rdat;
    end
  end

  // ==========================================
  // Device pins
  always_comb begin
    dev_o.cs0_n = !(s_reg.io != tape_pkg::IO_IDLE && s_reg.port != tape_pkg::PORT_DATA);
    dev_o.cs1_n = !(s_reg.io != tape_pkg::IO_IDLE && s_reg.port == tape_pkg::PORT_DATA);
    dev_o.addr0 = s_reg.port == tape_pkg::PORT_CMD;
    dev_o.rd_n = !(s_reg.io == tape_pkg::IO_STB && !s_reg.wr);
    dev_o.wr_n = !(s_reg.io == tape_pkg::IO_STB && s_reg.wr);
    dev_o.data = s_reg.wdata;
    dev_o.data_oe = s_reg.io != tape_pkg::IO_IDLE && s_reg.wr;
  end

  assign src_ready = s_reg.ph == tape_pkg::P_XFER && s_reg.io == tape_pkg::IO_IDLE && s_reg.dir;
  assign snk_data = s_reg.snk;
  assign snk_valid = s_reg.snk_v;

  // ==========================================
  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.snk_v = 1'b0;
    // Setup is frozen while an operation runs
    if (apb_wr && idle && paddr == tape_pkg::OFS_COUNT) begin
      s_next.blk = pwdata[tape_pkg::COUNT_BLK +: 16];
      s_next.sense_n = pwdata[tape_pkg::COUNT_SENSE +: 8];
    end
    if (apb_wr && idle && paddr == tape_pkg::OFS_CTRL) begin
      s_next.dir = pwdata[tape_pkg::CTRL_DIR];
      s_next.op = pwdata[tape_pkg::CTRL_OP +: 8];
      s_next.opar = pwdata[tape_pkg::CTRL_PAR +: 8];
    end

    // Port access engine: setup, strobe, end
    unique case (s_reg.io)
      tape_pkg::IO_IDLE: begin
      end
      tape_pkg::IO_SET: begin
        s_next.io = tape_pkg::IO_STB;
        s_next.stb = tape_pkg::STB_CYC - 4'h1;
      end
      tape_pkg::IO_STB: begin
        if (s_reg.stb != 4'h0) begin
          s_next.stb = s_reg.stb - 4'h1;
        end else if (dev_i.wait_n) begin
          s_next.io = tape_pkg::IO_END;
          if (!s_reg.wr) begin
            s_next.rdat = dev_i.data;
          end
        end
      end
      tape_pkg::IO_END: begin
        s_next.io = tape_pkg::IO_IDLE;
      end
    endcase

    // Sequencer; acts on the end cycle of each access
    unique case (s_reg.ph)
      tape_pkg::P_IDLE: begin
        if (start) begin
          s_next.ph = tape_pkg::P_IBF;
          s_next.cmd = tape_pkg::C_OP;
          s_next.param = 1'b0;
          s_next.tail = 1'b0;
          s_next.done = 1'b0;
          s_next.abort = 1'b0;
          s_next.sense_i = 8'h00;
          s_next = poll(s_next);
        end
      end
      tape_pkg::P_IBF: begin
        if (fin) begin
          if (s_reg.rdat[tape_pkg::HS_OBF]) begin
            // Output-full during the end command is the normal status
            s_next.abort = s_reg.cmd != tape_pkg::C_EOT;
            s_next.ph = tape_pkg::P_SENSE;
            s_next = launch(s_next, tape_pkg::PORT_PARAM, 1'b0, 8'h00);
          end else if (!s_reg.rdat[tape_pkg::HS_IBF]) begin
            s_next.ph = tape_pkg::P_SEND;
            s_next = launch(s_next, s_reg.param ? tape_pkg::PORT_PARAM : tape_pkg::PORT_CMD, 1'b1, cbyte);
          end else begin
            s_next = poll(s_next);
          end
        end
      end
      tape_pkg::P_SEND: begin
        if (fin) begin
          s_next.param = !s_reg.param;
          if (!s_reg.param || s_reg.cmd == tape_pkg::C_OP) begin
            s_next.ph = tape_pkg::P_IBF;
            if (s_reg.param) begin
              s_next.cmd = tape_pkg::C_SOT;
            end
          end else if (s_reg.cmd == tape_pkg::C_SOT) begin
            s_next.ph = tape_pkg::P_RDY;
          end else begin
            s_next.ph = tape_pkg::P_OBF;
          end
          s_next = poll(s_next);
        end
      end
      tape_pkg::P_RDY: begin
        if (fin) begin
          if (s_reg.rdat[tape_pkg::HS_OBF]) begin
            s_next.abort = 1'b1;
            s_next.ph = tape_pkg::P_SENSE;
            s_next = launch(s_next, tape_pkg::PORT_PARAM, 1'b0, 8'h00);
          end else if (dev_i.intr) begin
            s_next.abort = 1'b1;
            s_next.ph = tape_pkg::P_OBF;
            s_next = poll(s_next);
          end else if (s_reg.rdat[tape_pkg::HS_RDY]) begin
            s_next.ph = tape_pkg::P_XFER;
            s_next.cnt = s_reg.tail ? 10'h001 :
              s_reg.dir ? tape_pkg::BLOCK_BYTES : tape_pkg::FIRST_CHUNK;
          end else begin
            s_next = poll(s_next);
          end
        end
      end
      tape_pkg::P_XFER: begin
        // Tight loop: next byte starts as soon as the engine is free and, for writes, src_valid is high
        if (s_reg.io == tape_pkg::IO_IDLE && (!s_reg.dir || src_valid)) begin
          s_next = launch(s_next, tape_pkg::PORT_DATA, s_reg.dir, src_data);
        end
        if (fin) begin
          if (!s_reg.dir) begin
            s_next.snk = s_reg.rdat;
            s_next.snk_v = 1'b1;
          end
          if (s_reg.cnt != 10'h001) begin
            s_next.cnt = s_reg.cnt - 10'h001;
          end else if (s_reg.tail || s_reg.dir) begin
            s_next.blk = s_reg.blk - 16'h0001;
            s_next.tail = 1'b0;
            if (s_reg.blk == tape_pkg::LAST_BLOCK) begin
              s_next.ph = tape_pkg::P_IBF;
              s_next.cmd = tape_pkg::C_EOT;
              s_next.param = 1'b0;
              s_next = poll(s_next);
            end else if (s_reg.dir) begin
              s_next.ph = tape_pkg::P_RDY;
              s_next = poll(s_next);
            end else begin
              s_next.cnt = tape_pkg::FIRST_CHUNK;
            end
          end else if (s_reg.blk == tape_pkg::LAST_BLOCK) begin
            s_next.cnt = 10'h001;
            s_next.tail = 1'b1;
          end else begin
            s_next.tail = 1'b1;
            s_next.ph = tape_pkg::P_RDY;
            s_next = poll(s_next);
          end
        end
      end
      tape_pkg::P_OBF: begin
        if (fin) begin
          if (s_reg.rdat[tape_pkg::HS_OBF]) begin
            s_next.ph = tape_pkg::P_SENSE;
            s_next = launch(s_next, tape_pkg::PORT_PARAM, 1'b0, 8'h00);
          end else begin
            s_next = poll(s_next);
          end
        end
      end
      tape_pkg::P_SENSE: begin
        if (fin) begin
          if (s_reg.sense_i == 8'h00) begin
            s_next.sense0 = s_reg.rdat;
          end
          s_next.sense_i = s_reg.sense_i + 8'h01;
          if (s_reg.sense_i + 8'h01 >= s_reg.sense_n) begin
            s_next.ph = tape_pkg::P_IDLE;
            s_next.done = 1'b1;
          end else begin
            s_next.ph = tape_pkg::P_OBF;
            s_next = poll(s_next);
          end
        end
      end
      default: begin
        s_next.ph = tape_pkg::P_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence block_ready;
    s_reg.ph == tape_pkg::P_RDY && fin && s_reg.rdat[tape_pkg::HS_RDY]
      && !s_reg.rdat[tape_pkg::HS_OBF] && !dev_i.intr;
  endsequence

  sequence sense_read_starts;
    s_reg.ph == tape_pkg::P_SENSE && s_reg.io == tape_pkg::IO_SET
      ##1 !dev_o.rd_n && !dev_o.cs0_n && !dev_o.addr0;
  endsequence

  a_wait_hold:
  assert property (strobe && !dev_i.wait_n |=> strobe)
    else $error("Strobe released while wait held");

  a_ibf_clear:
  assert property (s_reg.ph == tape_pkg::P_SEND && s_reg.io == tape_pkg::IO_SET
    |-> !$past(s_reg.rdat[tape_pkg::HS_IBF]) && !dev_o.wr_n == 1'b0)
    else $error("Command byte sent while input buffer full");

  a_block_ready:
  assert property (block_ready |=> s_reg.ph == tape_pkg::P_XFER)
    else $error("Ready block not transferred");

  a_chunk_len:
  assert property ($past(s_reg.ph) == tape_pkg::P_RDY && s_reg.ph == tape_pkg::P_XFER
    |-> s_reg.cnt == (s_reg.tail ? 10'h001 : s_reg.dir ? 10'h200 : 10'h1ff))
    else $error("Wrong chunk length after buffer ready");

  a_obf_abort:
  assert property (s_reg.ph inside {tape_pkg::P_IBF, tape_pkg::P_RDY} && fin
    && s_reg.rdat[tape_pkg::HS_OBF] |=> sense_read_starts)
    else $error("Output full did not lead to sense read");

  a_intr_poll:
  assert property (s_reg.ph == tape_pkg::P_RDY && fin && dev_i.intr && !s_reg.rdat[tape_pkg::HS_OBF]
    |=> s_reg.ph == tape_pkg::P_OBF && s_reg.abort)
    else $error("Interrupt did not start status polling");

  a_cmd_codes:
  assert property (s_reg.ph == tape_pkg::P_SEND && s_reg.io == tape_pkg::IO_SET && !s_reg.param
    && s_reg.cmd != tape_pkg::C_OP |-> s_reg.wdata == (s_reg.cmd == tape_pkg::C_SOT ? 8'h40 : 8'h80)
    ##1 !dev_o.wr_n && dev_o.addr0)
    else $error("Bad transfer command code");

  a_data_port:
  assert property (strobe && s_reg.ph == tape_pkg::P_XFER |-> !dev_o.cs1_n && dev_o.cs0_n)
    else $error("Data moved outside data window");

  a_whole_blocks:
  assert property ($past(s_reg.ph) == tape_pkg::P_XFER && s_reg.ph == tape_pkg::P_IBF
    |-> s_reg.cmd == tape_pkg::C_EOT && s_reg.blk == 16'h0000)
    else $error("End of transfer before last block");

endmodule

// File: verilog/tape_pkg.sv
// Constants, types and carriers of the tape programmed-I/O host controller
package tape_pkg;
  // ==========================================
  // Own register map (APB, one word each)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam int CTRL_GO = 0;
  localparam int CTRL_DIR = 1;
  localparam int CTRL_OP = 8;
  localparam int CTRL_PAR = 16;
  localparam int COUNT_BLK = 0;
  localparam int COUNT_SENSE = 16;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ABORT = 2;
  localparam int STAT_SENSE0 = 8;
  localparam int STAT_SENSE_N = 16;
  localparam int STAT_PORT = 24;
  // ==========================================
  // Device host_interface_status bits
  localparam int HS_OBF = 0;
  localparam int HS_IBF = 1;
  localparam int HS_RDY = 7;
  // ==========================================
  // Command codes and block sizes
  localparam logic [7:0] SOT_CODE = 8'h40;
  localparam logic [7:0] EOT_CODE = 8'h80;
  localparam logic [7:0] XFER_PARAM = 8'h00;
  localparam logic [9:0] BLOCK_BYTES = 10'h200;
  localparam logic [9:0] FIRST_CHUNK = 10'h1ff;
  localparam logic [15:0] LAST_BLOCK = 16'h0001;
  // ==========================================
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int STROBE_NS = 100;
  localparam logic [3:0] STB_CYC = 4'((STROBE_NS * CLK_MHZ + 999) / 1000);
  // ==========================================
  // Types
  typedef enum logic [2:0] {
    P_IDLE = 3'h0, P_IBF = 3'h1, P_SEND = 3'h3, P_RDY = 3'h2,
    P_XFER = 3'h6, P_OBF = 3'h7, P_SENSE = 3'h5
  } phase_t;
  typedef enum logic [1:0] {IO_IDLE = 2'h0, IO_SET = 2'h1, IO_STB = 2'h3, IO_END = 2'h2} io_t;
  typedef enum logic [1:0] {C_OP = 2'h0, C_SOT = 2'h1, C_EOT = 2'h3} cmd_t;
  typedef enum logic [1:0] {PORT_PARAM = 2'h0, PORT_CMD = 2'h1, PORT_DATA = 2'h3} port_t;
  typedef struct packed {
    logic cs0_n;
    logic cs1_n;
    logic addr0;
    logic rd_n;
    logic wr_n;
    logic [7:0] data;
    logic data_oe;
  } dev_out_t;
  typedef struct packed {
    logic [7:0] data;
    logic wait_n;
    logic intr;
  } dev_in_t;
  typedef struct packed {
    phase_t ph;
    io_t io;
    port_t port;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] rdat;
    logic [3:0] stb;
    cmd_t cmd;
    logic param;
    logic dir;
    logic [7:0] op;
    logic [7:0] opar;
    logic [15:0] blk;
    logic [9:0] cnt;
    logic tail;
    logic [7:0] sense_n;
    logic [7:0] sense_i;
    logic [7:0] sense0;
    logic done;
    logic abort;
    logic [7:0] snk;
    logic snk_v;
  } state_t;
endpackage
